// file: core/fpu_regfile_pkg.sv
`default_nettype none
package fpu_regfile_pkg;

	// Bank and view geometry
	localparam int WORD_W    = 32;
	localparam int PAIR_W    = 64;
	localparam int QUAD_W    = 128;
	localparam int MTRX_W    = 512;
	localparam int NUM_WORDS = 16;
	localparam int NUM_PAIRS = 8;
	localparam int NUM_QUADS = 4;
	localparam int IDX_W     = 4;

	// Control/status word layout
	localparam int BANK_SWAP_POS  = 21;
	localparam int PAIR_MOVE_POS  = 20;
	localparam int DOUBLE_OP_POS  = 19;
	localparam int TINY_FLUSH_POS = 18;
	localparam int CAUSE_HI       = 17;
	localparam int CAUSE_LO       = 12;
	localparam int ENABLE_HI      = 11;
	localparam int ENABLE_LO      = 7;
	localparam int FLAG_HI        = 6;
	localparam int FLAG_LO        = 2;
	localparam int ROUND_HI       = 1;
	localparam int ROUND_LO       = 0;
	localparam int CAUSE_W        = 6;
	localparam int SRC_W          = 5;

	// Exception source positions inside a six-bit source vector
	localparam int SRC_ERR = 5;
	localparam int SRC_INV = 4;
	localparam int SRC_DVZ = 3;
	localparam int SRC_OVF = 2;
	localparam int SRC_UNF = 1;
	localparam int SRC_INX = 0;

	// Writable bits of the control word; bits 31..22 stay zero
	localparam logic [31:0] CTL_WRITE_MASK = 32'h003F_FFFF;
	localparam logic [31:0] CTL_RESET      = 32'h0004_0001;
	localparam logic [31:0] XFER_RESET     = 32'h0000_0000;

	// Rounding mode codes
	localparam logic [1:0] RND_NEAREST = 2'h0;
	localparam logic [1:0] RND_ZERO    = 2'h1;

	// Rounding unit geometry and exponent limits (biased)
	localparam int SIG_W     = 55;
	localparam int EXP_IN_W  = 12;
	localparam int S_EXP_W   = 8;
	localparam int S_FRAC_W  = 23;
	localparam int D_EXP_W   = 11;
	localparam int D_FRAC_W  = 52;
	localparam int S_EMAX    = 127;
	localparam int S_BIAS    = 127;
	localparam int D_EMAX    = 1023;
	localparam int D_BIAS    = 1023;
	localparam logic [12:0] S_EMAX_BIASED = 13'(S_EMAX + S_BIAS);
	localparam logic [12:0] D_EMAX_BIASED = 13'(D_EMAX + D_BIAS);

endpackage : fpu_regfile_pkg
`default_nettype wire

// file: core/fpu_round_unit.sv
`default_nettype none
module fpu_round_unit
	import fpu_regfile_pkg::*;
(
	input  wire logic                dbl,
	input  wire logic                toward_zero,
	input  wire logic                sign,
	input  wire logic [EXP_IN_W-1:0] exp_in,
	input  wire logic [SIG_W-1:0]    sig_in,
	output logic      [PAIR_W-1:0]   result,
	output logic                     ovf,
	output logic                     inx
);

	logic        lsb;
	logic        rnd_bit;
	logic        sticky;
	logic        inc;
	logic        carry;
	logic [53:0] sum_d;
	logic [24:0] sum_s;
	logic [12:0] exp_r;
	logic [12:0] emax_b;

	// Significand is normalised with its hidden bit at the top of sig_in
	always_comb begin
		if (dbl) begin
			lsb     = sig_in[2];
			rnd_bit = sig_in[1];
			sticky  = sig_in[0];
		end else begin
			lsb     = sig_in[31];
			rnd_bit = sig_in[30];
			sticky  = |sig_in[29:0];
		end
		inx    = rnd_bit | sticky;
		// Nearest: up when above half or tie with odd lsb; zero: drop round bit and below
		inc    = ~toward_zero & rnd_bit & (sticky | lsb);
		sum_d  = {1'b0, sig_in[54:2]} + {53'h0, inc};
		sum_s  = {1'b0, sig_in[54:31]} + {24'h0, inc};
		carry  = dbl ? sum_d[53] : sum_s[24];
		exp_r  = {1'b0, exp_in} + {12'h0, carry};
		emax_b = dbl ? D_EMAX_BIASED : S_EMAX_BIASED;
		ovf    = exp_r > emax_b;
		if (dbl)
			result = {sign, exp_r[D_EXP_W-1:0], carry ? {D_FRAC_W{1'b0}} : sum_d[D_FRAC_W-1:0]};
		else
			result = {32'h0, sign, exp_r[S_EXP_W-1:0], carry ? {S_FRAC_W{1'b0}} : sum_s[S_FRAC_W-1:0]};
		// Out of range: infinity when nearest, largest finite when toward zero
		if (ovf) begin
			inx = 1'b1;
			if (toward_zero) begin
				if (dbl)
					result = {sign, D_EMAX_BIASED[D_EXP_W-1:0], {D_FRAC_W{1'b1}}};
				else
					result = {32'h0, sign, S_EMAX_BIASED[S_EXP_W-1:0], {S_FRAC_W{1'b1}}};
			end else begin
				if (dbl)
					result = {sign, {D_EXP_W{1'b1}}, {D_FRAC_W{1'b0}}};
				else
					result = {32'h0, sign, {S_EXP_W{1'b1}}, {S_FRAC_W{1'b0}}};
			end
		end
	end

endmodule : fpu_round_unit
`default_nettype wire

// file: core/fpu_bank_regfile_ctl.sv
`default_nettype none
module fpu_bank_regfile_ctl
	import fpu_regfile_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                resetn,
	// Float move write and read
	input  wire logic                mv_wr_en,
	input  wire logic                mv_wr_alt,
	input  wire logic [IDX_W-1:0]    mv_wr_idx,
	input  wire logic [PAIR_W-1:0]   mv_wr_data,
	input  wire logic                mv_rd_alt,
	input  wire logic [IDX_W-1:0]    mv_rd_idx,
	output logic      [PAIR_W-1:0]   mv_rd_data,
	// Operand views
	output logic      [WORD_W-1:0]   single_view_regs [NUM_WORDS],
	output logic      [PAIR_W-1:0]   pair_view_regs   [NUM_PAIRS],
	output logic      [QUAD_W-1:0]   quad_view_regs   [NUM_QUADS],
	output logic      [WORD_W-1:0]   alt_single_regs  [NUM_WORDS],
	output logic      [PAIR_W-1:0]   alt_pair_regs    [NUM_PAIRS],
	output logic      [MTRX_W-1:0]   alt_matrix_view,
	// Control word access and mode toggles
	input  wire logic                ctl_wr,
	input  wire logic [WORD_W-1:0]   ctl_wdata,
	input  wire logic                bank_toggle,
	input  wire logic                size_toggle,
	output logic      [WORD_W-1:0]   fpu_ctl_stat_word,
	output logic                     bank_swap_bit,
	output logic                     pair_move_bit,
	output logic                     double_op_bit,
	output logic                     gfx_undef,
	output logic                     tiny_flush_bit,
	output logic      [1:0]          round_sel_field,
	// Arithmetic instruction completion
	input  wire logic                op_done,
	input  wire logic [CAUSE_W-1:0]  op_src,
	// Rounding request
	input  wire logic                rnd_go,
	input  wire logic                rnd_sign,
	input  wire logic [EXP_IN_W-1:0] rnd_exp,
	input  wire logic [SIG_W-1:0]    rnd_sig,
	output logic      [PAIR_W-1:0]   rnd_result,
	output logic                     rnd_valid,
	// Transfer word
	input  wire logic                load_sys_op,
	input  wire logic                fpu_xfer_wr,
	input  wire logic [WORD_W-1:0]   xfer_wdata,
	output logic      [WORD_W-1:0]   cpu_fpu_xfer_word
);

	// Physical storage, two banks of sixteen words
	logic [WORD_W-1:0] phys_bank_word      [2][NUM_WORDS];
	logic [WORD_W-1:0] next_phys_bank_word [2][NUM_WORDS];
	logic [WORD_W-1:0] next_ctl;
	logic [WORD_W-1:0] next_xfer;
	logic [PAIR_W-1:0] next_mv_rd_data;
	logic [PAIR_W-1:0] next_rnd_result;
	logic              next_rnd_valid;
	logic [PAIR_W-1:0] round_out;
	logic              round_ovf;
	logic              round_inx;
	logic              fg_bank;
	logic [WORD_W-1:0] fg_word [NUM_WORDS];
	logic [WORD_W-1:0] bg_word [NUM_WORDS];
	// Next values of the registered operand views
	logic [WORD_W-1:0] next_single     [NUM_WORDS];
	logic [WORD_W-1:0] next_alt_single [NUM_WORDS];
	logic [PAIR_W-1:0] next_pair       [NUM_PAIRS];
	logic [PAIR_W-1:0] next_alt_pair   [NUM_PAIRS];
	logic [QUAD_W-1:0] next_quad       [NUM_QUADS];
	logic [MTRX_W-1:0] next_mtrx;

	// Reserved rounding codes fall back to nearest
	function automatic logic is_toward_zero(input logic [1:0] code);
		return code == RND_ZERO;
	endfunction : is_toward_zero

	// Phys bank of a view: foreground for normal, background for alternate
	function automatic logic bank_of(input logic swap, input logic alt);
		return swap ^ alt;
	endfunction : bank_of

	// Even word of the pair that holds an index; the low index bit is ignored
	function automatic logic [IDX_W-1:0] pair_base(input logic [IDX_W-1:0] idx);
		return {idx[IDX_W-1:1], 1'b0};
	endfunction : pair_base

	assign fg_bank = fpu_ctl_stat_word[BANK_SWAP_POS];

	// Foreground and background word selection
	generate
		for (genvar w = 0; w < NUM_WORDS; w++) begin : g_sel
			assign fg_word[w] = phys_bank_word[bank_of(fg_bank, 1'b0)][w];
			assign bg_word[w] = phys_bank_word[bank_of(fg_bank, 1'b1)][w];
		end
	endgenerate

	fpu_round_unit u_round (
		.dbl         (fpu_ctl_stat_word[DOUBLE_OP_POS]),
		.toward_zero (is_toward_zero(fpu_ctl_stat_word[ROUND_HI:ROUND_LO])),
		.sign        (rnd_sign),
		.exp_in      (rnd_exp),
		.sig_in      (rnd_sig),
		.result      (round_out),
		.ovf         (round_ovf),
		.inx         (round_inx)
	);

	// Storage writes: one word, or an even/odd pair when move size is 64
	always_comb begin
		logic          bk;
		logic [IDX_W-1:0] ev;
		bk = bank_of(fg_bank, mv_wr_alt);
		ev = pair_base(mv_wr_idx);
		next_phys_bank_word = phys_bank_word;
		if (mv_wr_en) begin
			if (fpu_ctl_stat_word[PAIR_MOVE_POS]) begin
				next_phys_bank_word[bk][ev]       = mv_wr_data[PAIR_W-1:WORD_W];
				next_phys_bank_word[bk][ev | 4'h1] = mv_wr_data[WORD_W-1:0];
			end else begin
				next_phys_bank_word[bk][mv_wr_idx] = mv_wr_data[WORD_W-1:0];
			end
		end
	end

	// Move read data: pair or zero-extended single
	always_comb begin
		logic          bk;
		logic [IDX_W-1:0] ev;
		bk = bank_of(fg_bank, mv_rd_alt);
		ev = pair_base(mv_rd_idx);
		if (fpu_ctl_stat_word[PAIR_MOVE_POS])
			next_mv_rd_data = {phys_bank_word[bk][ev], phys_bank_word[bk][ev | 4'h1]};
		else
			next_mv_rd_data = {32'h0, phys_bank_word[bk][mv_rd_idx]};
	end

	// Control word next value: write, toggles, exception recording
	always_comb begin
		logic [CAUSE_W-1:0] src;
		logic               instr;
		src   = op_src;
		instr = op_done | rnd_go;
		if (rnd_go) begin
			src[SRC_OVF] = src[SRC_OVF] | round_ovf;
			src[SRC_INX] = src[SRC_INX] | round_inx;
		end
		next_ctl = fpu_ctl_stat_word;
		if (ctl_wr)
			next_ctl = ctl_wdata & CTL_WRITE_MASK;
		else begin
			if (bank_toggle)
				next_ctl[BANK_SWAP_POS] = ~fpu_ctl_stat_word[BANK_SWAP_POS];
			if (size_toggle)
				next_ctl[PAIR_MOVE_POS] = ~fpu_ctl_stat_word[PAIR_MOVE_POS];
		end
		if (instr) begin
			// Cause cleared then loaded with this instruction's sources
			next_ctl[CAUSE_HI:CAUSE_LO] = src;
			// Flags only ever gain bits from hardware; set beats software clear
			next_ctl[FLAG_HI:FLAG_LO] = next_ctl[FLAG_HI:FLAG_LO] | src[SRC_W-1:0];
		end
	end

	// Transfer word: core load wins over unit-side write
	always_comb begin
		next_xfer = cpu_fpu_xfer_word;
		if (load_sys_op)
			next_xfer = xfer_wdata;
		else if (fpu_xfer_wr)
			next_xfer = xfer_wdata;
	end

	// Rounding result capture
	always_comb begin
		next_rnd_valid  = rnd_go;
		next_rnd_result = rnd_go ? round_out : rnd_result;
	end

	// Storage and control registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int b = 0; b < 2; b++)
				for (int w = 0; w < NUM_WORDS; w++)
					phys_bank_word[b][w] <= 32'h0;
			fpu_ctl_stat_word <= CTL_RESET;
			cpu_fpu_xfer_word <= XFER_RESET;
			mv_rd_data        <= 64'h0;
			rnd_result        <= 64'h0;
			rnd_valid         <= 1'b0;
		end else begin
			phys_bank_word    <= next_phys_bank_word;
			fpu_ctl_stat_word <= next_ctl;
			cpu_fpu_xfer_word <= next_xfer;
			mv_rd_data        <= next_mv_rd_data;
			rnd_result        <= next_rnd_result;
			rnd_valid         <= next_rnd_valid;
		end
	end

	// Registered mode outputs
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bank_swap_bit   <= CTL_RESET[BANK_SWAP_POS];
			pair_move_bit   <= CTL_RESET[PAIR_MOVE_POS];
			double_op_bit   <= CTL_RESET[DOUBLE_OP_POS];
			gfx_undef       <= CTL_RESET[DOUBLE_OP_POS];
			tiny_flush_bit  <= CTL_RESET[TINY_FLUSH_POS];
			round_sel_field <= CTL_RESET[ROUND_HI:ROUND_LO];
		end else begin
			bank_swap_bit   <= next_ctl[BANK_SWAP_POS];
			pair_move_bit   <= next_ctl[PAIR_MOVE_POS];
			double_op_bit   <= next_ctl[DOUBLE_OP_POS];
			gfx_undef       <= next_ctl[DOUBLE_OP_POS];
			tiny_flush_bit  <= next_ctl[TINY_FLUSH_POS];
			round_sel_field <= next_ctl[ROUND_HI:ROUND_LO];
		end
	end

	// View next values: pairs, quads and matrix are fixed slices of the two banks
	always_comb begin
		for (int w = 0; w < NUM_WORDS; w++) begin
			next_single[w]     = fg_word[w];
			next_alt_single[w] = bg_word[w];
			next_mtrx[MTRX_W-1-WORD_W*w -: WORD_W] = bg_word[w];
		end
		for (int p = 0; p < NUM_PAIRS; p++) begin
			next_pair[p]     = {fg_word[2*p], fg_word[2*p+1]};
			next_alt_pair[p] = {bg_word[2*p], bg_word[2*p+1]};
		end
		for (int q = 0; q < NUM_QUADS; q++) begin
			next_quad[q] = {fg_word[4*q], fg_word[4*q+1], fg_word[4*q+2], fg_word[4*q+3]};
		end
	end

	// Operand views, registered one cycle behind storage
	generate
		for (genvar w = 0; w < NUM_WORDS; w++) begin : g_single
			always_ff @(posedge clk) begin
				if (!resetn) begin
					single_view_regs[w] <= 32'h0;
					alt_single_regs[w]  <= 32'h0;
				end else begin
					single_view_regs[w] <= next_single[w];
					alt_single_regs[w]  <= next_alt_single[w];
				end
			end
		end
		for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
			always_ff @(posedge clk) begin
				if (!resetn) begin
					pair_view_regs[p] <= 64'h0;
					alt_pair_regs[p]  <= 64'h0;
				end else begin
					pair_view_regs[p] <= next_pair[p];
					alt_pair_regs[p]  <= next_alt_pair[p];
				end
			end
		end
		for (genvar q = 0; q < NUM_QUADS; q++) begin : g_quad
			always_ff @(posedge clk) begin
				if (!resetn)
					quad_view_regs[q] <= 128'h0;
				else
					quad_view_regs[q] <= next_quad[q];
			end
		end
		for (genvar m = 0; m < NUM_WORDS; m++) begin : g_mtrx
			always_ff @(posedge clk) begin
				if (!resetn)
					alt_matrix_view[MTRX_W-1-WORD_W*m -: WORD_W] <= 32'h0;
				else
					alt_matrix_view[MTRX_W-1-WORD_W*m -: WORD_W] <= next_mtrx[MTRX_W-1-WORD_W*m -: WORD_W];
			end
		end
	endgenerate

endmodule : fpu_bank_regfile_ctl
`default_nettype wire

// file: verification/core_model.sv
`default_nettype none
module core_model (
	input  wire logic        clk,
	output logic             ctl_wr,
	output logic      [31:0] ctl_wdata,
	output logic             load_sys_op,
	output logic             fpu_xfer_wr,
	output logic      [31:0] xfer_wdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus at time zero
	initial begin
		{ctl_wr, load_sys_op, fpu_xfer_wr} = 3'h0;
		ctl_wdata = 32'h0000_0000;
		xfer_wdata = 32'h0000_0000;
	end
	// Software load of the control word; gap sets how slowly it answers
	task automatic put_ctl(input logic [31:0] v, input int gap);
		repeat (gap) @(negedge clk);
		ctl_wdata = v & 32'h003F_FFFF;
		if (v[20])
			ctl_wdata[19] = 1'b0;
		ctl_wr = 1'b1;
		@(negedge clk);
		ctl_wr = 1'b0;
		ctl_wdata = ~ctl_wdata;
	endtask : put_ctl
	// Transfer word write from the core, or from the unit side
	task automatic put_xfer(input logic [31:0] v, input int gap, input logic unit);
		repeat (gap) @(negedge clk);
		xfer_wdata = v;
		load_sys_op = !unit;
		fpu_xfer_wr = unit;
		@(negedge clk);
		{load_sys_op, fpu_xfer_wr} = 2'h0;
		xfer_wdata = ~v;
	endtask : put_xfer
endmodule : core_model
`default_nettype wire

// file: verification/fpu_regfile_chk.sv
`default_nettype none
module fpu_regfile_chk
	import fpu_regfile_pkg::*;
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        ctl_wr,
	input wire logic        bank_toggle,
	input wire logic [31:0] fpu_ctl_stat_word,
	input wire logic        bank_swap_bit,
	input wire logic        op_done,
	input wire logic [5:0]  op_src,
	input wire logic        rnd_go,
	input wire logic        rnd_valid,
	input wire logic        load_sys_op,
	input wire logic [31:0] xfer_wdata,
	input wire logic [31:0] cpu_fpu_xfer_word
);
	timeunit 1ns;
	timeprecision 100ps;
	wire [31:0] w = fpu_ctl_stat_word;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Instruction end with no rounding request beside it
	sequence s_op; op_done && !rnd_go; endsequence
	property p_rsv; w[31:22] == 10'h000; endproperty
	property p_rst; $rose(resetn) |-> w == CTL_RESET; endproperty
	property p_cause; s_op |=> w[17:12] == $past(op_src); endproperty
	property p_flag; s_op |=> (w[6:2] & $past(op_src[4:0])) == $past(op_src[4:0]); endproperty
	property p_stick; !ctl_wr |=> (w[6:2] & $past(w[6:2])) == $past(w[6:2]); endproperty
	property p_bank; bank_toggle && !ctl_wr |=> bank_swap_bit != $past(bank_swap_bit); endproperty
	property p_xfer; load_sys_op |=> cpu_fpu_xfer_word == $past(xfer_wdata); endproperty
	property p_rnd; rnd_go |=> rnd_valid; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	a_rst: assert property (p_rst) else $error("bad reset word");
	a_cause: assert property (p_cause) else $error("bad cause");
	a_flag: assert property (p_flag) else $error("flag not set");
	a_stick: assert property (p_stick) else $error("flag lost");
	a_bank: assert property (p_bank) else $error("bank not flipped");
	a_xfer: assert property (p_xfer) else $error("bad transfer word");
	a_rnd: assert property (p_rnd) else $error("no round result");
endmodule : fpu_regfile_chk
bind fpu_bank_regfile_ctl fpu_regfile_chk u_chk (.clk, .resetn, .ctl_wr, .bank_toggle, .fpu_ctl_stat_word,
	.bank_swap_bit, .op_done, .op_src, .rnd_go, .rnd_valid, .load_sys_op, .xfer_wdata, .cpu_fpu_xfer_word);
`default_nettype wire

// file: verification/testbench.sv
`default_nettype none
module testbench
	import fpu_regfile_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic         clk = 1'b0;
	logic         resetn, mv_wr_en, mv_wr_alt, mv_rd_alt, bank_toggle, size_toggle, op_done, rnd_go, rnd_sign;
	logic         ctl_wr, load_sys_op, fpu_xfer_wr, rnd_valid, bank, pair;
	logic [3:0]   mv_wr_idx, mv_rd_idx;
	logic [5:0]   op_src;
	logic [6:0]   modes;
	logic [11:0]  rnd_exp;
	logic [54:0]  rnd_sig;
	logic [63:0]  mv_wr_data, mv_rd_data, rnd_result, pv [8], ap [8];
	logic [127:0] qv [4];
	logic [511:0] mx;
	logic [31:0]  ctl_wdata, xfer_wdata, word, xfer, sv [16], asv [16], phys [2][16];
	int           miscompares, check_count, cycles;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	fpu_bank_regfile_ctl uut (.clk, .resetn, .mv_wr_en, .mv_wr_alt, .mv_wr_idx, .mv_wr_data, .mv_rd_alt, .mv_rd_idx,
		.mv_rd_data, .single_view_regs(sv), .pair_view_regs(pv), .quad_view_regs(qv), .alt_single_regs(asv),
		.alt_pair_regs(ap), .alt_matrix_view(mx), .ctl_wr, .ctl_wdata, .bank_toggle, .size_toggle,
		.fpu_ctl_stat_word(word), .bank_swap_bit(modes[6]), .pair_move_bit(modes[5]), .double_op_bit(modes[4]),
		.tiny_flush_bit(modes[3]), .round_sel_field(modes[2:1]), .gfx_undef(modes[0]), .op_done, .op_src, .rnd_go,
		.rnd_sign, .rnd_exp, .rnd_sig, .rnd_result, .rnd_valid, .load_sys_op, .fpu_xfer_wr, .xfer_wdata,
		.cpu_fpu_xfer_word(xfer));
	core_model cm (.clk, .ctl_wr, .ctl_wdata, .load_sys_op, .fpu_xfer_wr, .xfer_wdata);
	task automatic cmp(input logic [511:0] got, exp, input string what);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %0h", $time, what, got);
		end
	endtask : cmp
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	// Move write, one a cycle; the storage model follows bank and size
	task automatic mv(input logic alt, input logic [3:0] i, input logic [63:0] d);
		logic b;
		b = alt ^ bank;
		{mv_wr_en, mv_wr_alt, mv_wr_idx, mv_wr_data} = {1'b1, alt, i, d};
		if (pair) begin
			phys[b][i & 4'hE] = d[63:32];
			phys[b][i | 4'h1] = d[31:0];
		end else
			phys[b][i] = d[31:0];
		tick(1);
	endtask : mv
	task automatic views();
		for (int i = 0; i < 16; i++) begin
			cmp(sv[i], phys[bank][i], "single");
			cmp(asv[i], phys[!bank][i], "alt single");
			cmp(mx[511-32*i -: 32], phys[!bank][i], "matrix");
		end
		for (int p = 0; p < 8; p++) begin
			cmp(pv[p], {phys[bank][2*p], phys[bank][2*p+1]}, "pair");
			cmp(ap[p], {phys[!bank][2*p], phys[!bank][2*p+1]}, "alt pair");
		end
		for (int q = 0; q < 4; q++)
			cmp(qv[q], {phys[bank][4*q], phys[bank][4*q+1], phys[bank][4*q+2], phys[bank][4*q+3]}, "quad");
	endtask : views
	// Single or double precision rounding of a normalised input
	function automatic logic [63:0] rexp(logic s, logic [11:0] e, logic [54:0] g, logic tz, logic d);
		logic [53:0] m;
		logic [12:0] x;
		logic        up;
		m = d ? {1'b0, g[54:2]} : {30'h0, g[54:31]};
		x = {1'b0, e};
		up = d ? (g[1] && (g[0] || g[2])) : (g[30] && ((|g[29:0]) || g[31]));
		if (!tz && up)
			m = m + 54'h1;
		if (d ? m[53] : m[24]) begin
			m = m >> 1;
			x = x + 13'h1;
		end
		if (x > (d ? 13'h07FE : 13'h00FE))
			return d ? {s, tz ? 63'h7FEF_FFFF_FFFF_FFFF : 63'h7FF0_0000_0000_0000}
				: {32'h0, s, tz ? 31'h7F7F_FFFF : 31'h7F80_0000};
		return d ? {s, x[10:0], m[51:0]} : {32'h0, s, x[7:0], m[22:0]};
	endfunction : rexp
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		logic [31:0] v;
		logic [5:0] s;
		logic [4:0] fl;
		logic [54:0] g;
		logic [11:0] e;
		{resetn, mv_wr_en, mv_wr_alt, mv_rd_alt, bank_toggle, size_toggle, op_done, rnd_go, rnd_sign} = '0;
		{mv_wr_idx, mv_rd_idx, mv_wr_data, op_src, rnd_exp, rnd_sig, bank, pair, fl} = '0;
		phys = '{default: '0};
		void'($urandom(89646));
		tick(6);
		resetn = 1'b1;
		cmp(word, CTL_RESET, "reset word");
		cmp(xfer, XFER_RESET, "reset xfer");
		for (int k = 0; k < 40; k++)
			mv(1'($urandom), 4'($urandom), {$urandom, $urandom});
		mv_wr_en = 1'b0;
		{mv_rd_alt, mv_rd_idx} = 5'($urandom);
		tick(1);
		views();
		cmp(mv_rd_data, {32'h0, phys[mv_rd_alt ^ bank][mv_rd_idx]}, "move read");
		pulse(bank_toggle);
		bank = 1'b1;
		pulse(size_toggle);
		pair = 1'b1;
		for (int k = 0; k < 16; k++)
			mv(1'($urandom), 4'($urandom), {$urandom, $urandom});
		mv_wr_en = 1'b0;
		{mv_rd_alt, mv_rd_idx} = 5'h05;
		tick(1);
		views();
		cmp(mv_rd_data, {phys[bank][4], phys[bank][5]}, "pair read");
		$display("views test done");
		for (int k = 0; k < 12; k++) begin
			s = (k == 5) ? 6'h00 : 6'($urandom);
			{op_done, op_src} = {1'b1, s};
			fl |= s[4:0];
			tick(1);
			cmp(word[17:12], s, "cause");
			cmp(word[6:2], fl, "flags");
		end
		op_done = 1'b0;
		for (int k = 0; k < 12; k++) begin
			v = $urandom;
			cm.put_ctl(v, 1 + $urandom_range(2));
			v = v & CTL_WRITE_MASK;
			if (v[20])
				v[19] = 1'b0;
			cmp(word, v, "ctl word");
			cmp(modes, {v[21:18], v[1:0], v[19]}, "modes");
		end
		{bank, pair} = v[21:20];
		tick(1);
		views();
		for (int k = 0; k < 6; k++) begin
			v = $urandom;
			cm.put_xfer(v, 1 + k % 2, 1'(k));
			cmp(xfer, v, "xfer");
		end
		$display("control test done");
		for (int m = 0; m < 8; m++) begin
			cm.put_ctl({12'h000, m[2], 17'h00000, m[1:0]}, 1);
			for (int k = 0; k < 12; k++) begin
				e = 12'(1 + $urandom_range(253));
				g = {1'b1, 54'({$urandom, $urandom})};
				if (k == 0)
					{e, g} = {m[2] ? 12'h7FE : 12'h0FE, {55{1'b1}}};
				if (k == 1)
					g[30:0] = m[2] ? {g[30:2], 2'h2} : 31'h4000_0000;
				if (k == 2)
					g[31:0] = m[2] ? {g[31:3], 3'h6} : 32'hC000_0000;
				if (k == 3)
					e = m[2] ? 12'h7FF : 12'h100;
				{rnd_go, rnd_sign, rnd_exp, rnd_sig} = {1'b1, 1'($urandom), e, g};
				tick(1);
				cmp(rnd_valid, 1'b1, "valid");
				cmp(rnd_result, rexp(rnd_sign, e, g, m[1:0] == 2'h1, m[2]), "round");
			end
			rnd_go = 1'b0;
		end
		$display("round test done");
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
